// ===== rtl/isf_pkg.sv
package isf_pkg;
    // Register byte addresses on the Avalon-MM slave
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] OFS_STATUS = 5'h00;
    localparam logic [4:0] OFS_XFER = 5'h04;
    localparam logic [4:0] OFS_CTRL = 5'h08;
    localparam logic [4:0] OFS_DATA = 5'h0C;
    localparam logic [4:0] OFS_IRQ_ST = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h14;

    // Bit positions in bus_status_flags
    localparam int unsigned ST_ERROR_STOP_FLAG = 7;
    localparam int unsigned ST_STOP = 6;
    localparam int unsigned ST_CONTINUOUS_TRANSFER_IRQ_FLAG = 5;
    localparam int unsigned ST_SECOND_ADDRESS_MATCH_FLAG = 4;
    localparam int unsigned ST_AL = 3;
    localparam int unsigned ST_AAS = 2;
    localparam int unsigned ST_ADZ = 1;
    localparam int unsigned ST_RECEIVED_ACK_BIT = 0;
    // Bits cleared by read-one then write-zero; the ack bit is read only
    localparam logic [7:0] ST_SW_CLR = 8'hFE;

    // Bit positions in the transfer flag register
    localparam int unsigned XF_TBE = 0;
    localparam int unsigned XF_RBF = 1;
    localparam int unsigned XF_BUS_BUSY_FLAG = 2;
    localparam int unsigned XF_TRS = 3;
    localparam int unsigned XF_W = 4;

    // Bit positions in bus_control_reg
    localparam int unsigned CT_INTERFACE_IRQ_FLAG = 0;
    localparam int unsigned CT_MS = 1;

    // Interrupt event bits
    localparam int unsigned IRQ_START = 0;
    localparam int unsigned IRQ_STOP = 1;
    localparam int unsigned IRQ_ADDR = 2;
    localparam int unsigned IRQ_FRAME = 3;
    localparam int unsigned IRQ_ESTOP = 4;
    localparam int unsigned IRQ_N = 5;

    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [3:0] XFER_RST = 4'h0;
    localparam logic [7:0] TXDATA_RST = 8'h00;
    localparam logic [4:0] IRQ_MASK_RST = 5'h00;
    localparam logic [31:0] RDATA_RST = 32'h00000000;

    // Bus answer states
    typedef enum logic [1:0] {
        ISF_BS_IDLE = 2'b01,
        ISF_BS_ACK = 2'b10
    } isf_bus_e;
endpackage

// ===== rtl/isf_irq.sv
`timescale 1ns/1ps
module isf_irq #(
    parameter int unsigned N = 5
) (
    input wire logic core_clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic [N-1:0] ev, // Event pulses
    input wire logic wr_st, // Write to status, one clears
    input wire logic wr_mask, // Write to mask
    input wire logic [N-1:0] wdata, // Write data
    output logic [N-1:0] status, // Sticky status bits
    output logic [N-1:0] mask, // Mask bits
    output logic irq // Level interrupt, registered
);
    logic [N-1:0] st_d;
    logic [N-1:0] st_q;
    logic [N-1:0] mask_d;
    logic [N-1:0] mask_q;
    logic irq_d;
    logic irq_q;

    // Per-bit sticky flag, set wins over a same-cycle clear
    for (genvar i = 0; i < N; i++)
    begin : g_bit
        always_comb
        begin
            st_d[i] = st_q[i];
            if (wr_st && wdata[i])
            begin
                st_d[i] = 1'b0;
            end
            if (ev[i])
            begin
                st_d[i] = 1'b1;
            end
        end
    end

    // Mask and output level
    always_comb
    begin
        mask_d = wr_mask ? wdata : mask_q;
        irq_d = |(st_d & mask_d);
    end

    // Registers only
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st_q <= '0;
            mask_q <= isf_pkg::IRQ_MASK_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    assign status = st_q;
    assign mask = mask_q;
    assign irq = irq_q;
endmodule // isf_irq

// ===== rtl/isf_slave_flags.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module isf_slave_flags (
    input wire logic core_clk, // System clock, 125 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic [4:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall, low answers
    input wire logic ev_start, // Start condition pulse
    input wire logic ev_stop, // Stop condition pulse
    input wire logic ev_addr, // First frame done pulse
    input wire logic match_first, // Frame matched first address
    input wire logic match_second, // Frame matched second address
    input wire logic match_gcall, // Frame was general call
    input wire logic rw_bit, // Read/write bit after address
    input wire logic ev_tx_end, // Transmit frame end pulse
    input wire logic ev_rx_end, // Receive frame end pulse
    input wire logic frame_busy, // Frame in transfer
    input wire logic ack_in, // Ack bit seen at transmit end
    input wire logic ev_arb_lost, // Arbitration lost pulse
    input wire logic [7:0] rx_data, // Received byte
    output logic [7:0] tx_data, // Byte for transmission
    output logic tx_load, // One-cycle pulse on buffer write
    output logic transmit_select, // Slave transmitting
    output logic bus_busy_flag, // Bus busy
    output logic irq // Level interrupt
);
    isf_pkg::isf_bus_e bs_d;
    isf_pkg::isf_bus_e bs_q;
    logic wait_d;
    logic wait_q;
    logic [31:0] rd_d;
    logic [31:0] rd_q;
    logic acc_rd;
    logic acc_wr;
    logic lane0;
    logic [7:0] st_d;
    logic [7:0] st_q;
    logic [7:0] arm_d;
    logic [7:0] arm_q;
    logic [3:0] xf_d;
    logic [3:0] xf_q;
    logic interface_irq_flag_d;
    logic interface_irq_flag_q;
    logic iarm_d;
    logic iarm_q;
    logic ms_d;
    logic ms_q;
    logic [7:0] txd_d;
    logic [7:0] txd_q;
    logic load_d;
    logic load_q;
    logic slave;
    logic hit_match;
    logic [isf_pkg::IRQ_N-1:0] irq_ev;
    logic [isf_pkg::IRQ_N-1:0] irq_st;
    logic [isf_pkg::IRQ_N-1:0] irq_mask;

    // Answer each request one cycle after it appears, never sooner
    always_comb
    begin
        bs_d = bs_q;
        unique case (bs_q)
            isf_pkg::ISF_BS_IDLE:
                if (avs_read || avs_write)
                begin
                    bs_d = isf_pkg::ISF_BS_ACK;
                end
            isf_pkg::ISF_BS_ACK:
                bs_d = isf_pkg::ISF_BS_IDLE;
        endcase
        wait_d = (bs_d != isf_pkg::ISF_BS_ACK);
        rd_d = rd_q;
        if (bs_q == isf_pkg::ISF_BS_IDLE)
        begin
            // Unmapped addresses read as zero
            unique case (avs_address)
                isf_pkg::OFS_STATUS: rd_d = {24'h000000, st_q};
                isf_pkg::OFS_XFER: rd_d = {28'h0000000, xf_q};
                isf_pkg::OFS_CTRL: rd_d = {30'h00000000, ms_q, interface_irq_flag_q};
                isf_pkg::OFS_DATA: rd_d = {24'h000000, rx_data};
                isf_pkg::OFS_IRQ_ST: rd_d = {27'h0000000, irq_st};
                isf_pkg::OFS_IRQ_MASK: rd_d = {27'h0000000, irq_mask};
                default: rd_d = isf_pkg::RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            bs_q <= isf_pkg::ISF_BS_IDLE;
            wait_q <= 1'b1;
            rd_q <= isf_pkg::RDATA_RST;
        end
        else
        begin
            bs_q <= bs_d;
            wait_q <= wait_d;
            rd_q <= rd_d;
        end
    end

    // Side effects happen only at the accepting edge
    assign acc_rd = (bs_q == isf_pkg::ISF_BS_ACK) && avs_read;
    assign acc_wr = (bs_q == isf_pkg::ISF_BS_ACK) && avs_write;
    assign lane0 = avs_byteenable[0];
    // Flags only follow the bus while not in master mode, except arbitration lost, which sets in either mode
    assign slave = !ms_q;
    assign hit_match = ev_addr && (match_first || match_second || match_gcall);

    // Flag update: software clears first, hardware sets override them
    always_comb
    begin
        st_d = st_q;
        xf_d = xf_q;
        interface_irq_flag_d = interface_irq_flag_q;
        arm_d = arm_q;
        iarm_d = iarm_q;
        ms_d = ms_q;
        txd_d = txd_q;
        load_d = 1'b0;
        if (acc_rd && avs_address == isf_pkg::OFS_STATUS)
        begin
            arm_d = arm_q | st_q;
        end
        if (acc_rd && avs_address == isf_pkg::OFS_CTRL)
        begin
            iarm_d = iarm_q | interface_irq_flag_q;
        end
        if (acc_wr && lane0 && avs_address == isf_pkg::OFS_STATUS)
        begin
            st_d = st_q & ~(arm_q & ~avs_writedata[7:0] & isf_pkg::ST_SW_CLR);
        end
        if (acc_wr && lane0 && avs_address == isf_pkg::OFS_CTRL)
        begin
            ms_d = avs_writedata[isf_pkg::CT_MS];
            if (iarm_q && !avs_writedata[isf_pkg::CT_INTERFACE_IRQ_FLAG])
            begin
                interface_irq_flag_d = 1'b0;
                st_d[isf_pkg::ST_ERROR_STOP_FLAG] = 1'b0;
                st_d[isf_pkg::ST_STOP] = 1'b0;
                st_d[isf_pkg::ST_CONTINUOUS_TRANSFER_IRQ_FLAG] = 1'b0;
            end
        end
        if (acc_wr && lane0 && avs_address == isf_pkg::OFS_DATA)
        begin
            txd_d = avs_writedata[7:0];
            load_d = 1'b1;
            xf_d[isf_pkg::XF_TBE] = 1'b0;
            st_d[isf_pkg::ST_AL] = 1'b0;
            st_d[isf_pkg::ST_AAS] = 1'b0;
        end
        if (acc_rd && avs_address == isf_pkg::OFS_DATA)
        begin
            xf_d[isf_pkg::XF_RBF] = 1'b0;
            st_d[isf_pkg::ST_AL] = 1'b0;
            st_d[isf_pkg::ST_ADZ] = 1'b0;
            st_d[isf_pkg::ST_AAS] = 1'b0;
        end
        if (ev_arb_lost)
        begin
            st_d[isf_pkg::ST_AL] = 1'b1;
        end
        if (slave)
        begin
            if (ev_start)
            begin
                xf_d[isf_pkg::XF_BUS_BUSY_FLAG] = 1'b1;
                xf_d[isf_pkg::XF_TBE] = 1'b1;
                st_d[isf_pkg::ST_SECOND_ADDRESS_MATCH_FLAG] = 1'b0;
                interface_irq_flag_d = 1'b1;
            end
            if (hit_match)
            begin
                xf_d[isf_pkg::XF_TRS] = rw_bit;
                xf_d[isf_pkg::XF_RBF] = 1'b1;
                interface_irq_flag_d = 1'b1;
            end
            if (ev_addr && match_first && !match_second)
            begin
                st_d[isf_pkg::ST_AAS] = 1'b1;
            end
            if (ev_addr && match_second && !match_first)
            begin
                st_d[isf_pkg::ST_SECOND_ADDRESS_MATCH_FLAG] = 1'b1;
                st_d[isf_pkg::ST_AAS] = 1'b0;
                st_d[isf_pkg::ST_CONTINUOUS_TRANSFER_IRQ_FLAG] = 1'b1;
            end
            if (ev_addr && match_gcall)
            begin
                st_d[isf_pkg::ST_AAS] = 1'b1;
                st_d[isf_pkg::ST_ADZ] = 1'b1;
            end
            if (ev_tx_end)
            begin
                xf_d[isf_pkg::XF_TBE] = 1'b1;
                st_d[isf_pkg::ST_RECEIVED_ACK_BIT] = ack_in;
                interface_irq_flag_d = 1'b1;
            end
            if (ev_rx_end)
            begin
                xf_d[isf_pkg::XF_RBF] = 1'b1;
                interface_irq_flag_d = 1'b1;
            end
            // continuous flag gated by second match
            if ((ev_tx_end || ev_rx_end) && st_q[isf_pkg::ST_SECOND_ADDRESS_MATCH_FLAG])
            begin
                st_d[isf_pkg::ST_CONTINUOUS_TRANSFER_IRQ_FLAG] = 1'b1;
            end
            if (ev_stop)
            begin
                xf_d[isf_pkg::XF_BUS_BUSY_FLAG] = 1'b0;
                xf_d[isf_pkg::XF_TBE] = 1'b0;
                interface_irq_flag_d = 1'b1;
                // stop mid-frame
                // The other stop flag falls so both never show together
                if (frame_busy)
                begin
                    st_d[isf_pkg::ST_ERROR_STOP_FLAG] = 1'b1;
                    st_d[isf_pkg::ST_STOP] = 1'b0;
                end
                else
                begin
                    st_d[isf_pkg::ST_STOP] = 1'b1;
                    st_d[isf_pkg::ST_ERROR_STOP_FLAG] = 1'b0;
                end
            end
        end
        if (st_d[isf_pkg::ST_CONTINUOUS_TRANSFER_IRQ_FLAG] && !st_q[isf_pkg::ST_CONTINUOUS_TRANSFER_IRQ_FLAG])
        begin
            interface_irq_flag_d = 1'b1;
        end
        // A bit must be read as one again after it falls
        arm_d = arm_d & st_d;
        iarm_d = iarm_d & interface_irq_flag_d;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st_q <= isf_pkg::STATUS_RST;
            arm_q <= 8'h00;
            xf_q <= isf_pkg::XFER_RST;
            interface_irq_flag_q <= 1'b0;
            iarm_q <= 1'b0;
            ms_q <= 1'b0;
            txd_q <= isf_pkg::TXDATA_RST;
            load_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            arm_q <= arm_d;
            xf_q <= xf_d;
            interface_irq_flag_q <= interface_irq_flag_d;
            iarm_q <= iarm_d;
            ms_q <= ms_d;
            txd_q <= txd_d;
            load_q <= load_d;
        end
    end

    // Interrupt sources
    assign irq_ev[isf_pkg::IRQ_START] = slave && ev_start;
    assign irq_ev[isf_pkg::IRQ_STOP] = slave && ev_stop && !frame_busy;
    assign irq_ev[isf_pkg::IRQ_ADDR] = slave && hit_match;
    assign irq_ev[isf_pkg::IRQ_FRAME] = slave && (ev_tx_end || ev_rx_end);
    assign irq_ev[isf_pkg::IRQ_ESTOP] = slave && ev_stop && frame_busy;

    isf_irq #(
        .N(isf_pkg::IRQ_N)
    ) u_irq (
        .core_clk(core_clk),
        .srst(srst),
        .ev(irq_ev),
        .wr_st(acc_wr && lane0 && avs_address == isf_pkg::OFS_IRQ_ST),
        .wr_mask(acc_wr && lane0 && avs_address == isf_pkg::OFS_IRQ_MASK),
        .wdata(avs_writedata[isf_pkg::IRQ_N-1:0]),
        .status(irq_st),
        .mask(irq_mask),
        .irq(irq)
    );

    assign avs_readdata = rd_q;
    assign avs_waitrequest = wait_q;
    assign tx_data = txd_q;
    assign tx_load = load_q;
    assign transmit_select = xf_q[isf_pkg::XF_TRS];
    assign bus_busy_flag = xf_q[isf_pkg::XF_BUS_BUSY_FLAG];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_quiet;
        !ev_start && !ev_stop && !ev_addr && !ev_tx_end && !ev_rx_end && !ev_arb_lost;
    endsequence
    // Error stop already read as one, so a zero write would clear it
    sequence s_error_stop_flag_armed;
        arm_q[isf_pkg::ST_ERROR_STOP_FLAG] && st_q[isf_pkg::ST_ERROR_STOP_FLAG];
    endsequence

    a_start_flags: assert property (slave && ev_start |=>
        xf_q[isf_pkg::XF_BUS_BUSY_FLAG] && xf_q[isf_pkg::XF_TBE] && !st_q[isf_pkg::ST_SECOND_ADDRESS_MATCH_FLAG])
        else $error("start did not set busy and empty");
    a_match1_flags: assert property (slave && ev_addr && match_first && !match_second
        |=> st_q[isf_pkg::ST_AAS] && xf_q[isf_pkg::XF_RBF] && !st_q[isf_pkg::ST_SECOND_ADDRESS_MATCH_FLAG])
        else $error("first match flags wrong");
    a_match2_flags: assert property (slave && ev_addr && match_second && !match_first
        |=> st_q[isf_pkg::ST_SECOND_ADDRESS_MATCH_FLAG] && st_q[isf_pkg::ST_CONTINUOUS_TRANSFER_IRQ_FLAG] && !st_q[isf_pkg::ST_AAS])
        else $error("second match flags wrong");
    a_trs_from_rw: assert property (slave && hit_match
        |=> transmit_select == $past(rw_bit))
        else $error("transmit select not from read bit");
    a_continuous_transfer_irq_flag_needs_second_address_match_flag: assert property ($rose(st_q[isf_pkg::ST_CONTINUOUS_TRANSFER_IRQ_FLAG])
        |-> $past(st_q[isf_pkg::ST_SECOND_ADDRESS_MATCH_FLAG]) || $past(ev_addr && match_second))
        else $error("continuous flag set without second match");
    a_tx_end_empty: assert property (slave && ev_tx_end && !ev_stop
        |=> xf_q[isf_pkg::XF_TBE] && bus_busy_flag == $past(bus_busy_flag))
        else $error("transmit end did not set empty");
    a_dbuf_wr_clr: assert property (acc_wr && lane0 && avs_address == isf_pkg::OFS_DATA
        ##0 s_quiet |=> !xf_q[isf_pkg::XF_TBE] && !st_q[isf_pkg::ST_AL] && tx_load)
        else $error("buffer write did not clear flags");
    a_rx_end_full: assert property (slave && ev_rx_end && !ev_stop
        |=> xf_q[isf_pkg::XF_RBF] && transmit_select == $past(transmit_select))
        else $error("receive end did not set full");
    a_stop_flags: assert property (slave && ev_stop |=>
        !bus_busy_flag && !xf_q[isf_pkg::XF_TBE]
        && (st_q[isf_pkg::ST_ERROR_STOP_FLAG] != st_q[isf_pkg::ST_STOP]))
        else $error("stop flags wrong");
    a_error_stop_flag_mid_frame: assert property (slave && ev_stop && frame_busy
        |=> st_q[isf_pkg::ST_ERROR_STOP_FLAG] && interface_irq_flag_q)
        else $error("error stop not set");
    a_error_stop_flag_w1_kept: assert property (s_error_stop_flag_armed ##0 (acc_wr
        && avs_address == isf_pkg::OFS_STATUS && avs_writedata[7]) |=> st_q[isf_pkg::ST_ERROR_STOP_FLAG])
        else $error("writing one changed error stop");
    a_interface_irq_flag_clr_error_stop_flag: assert property ($fell(interface_irq_flag_q) |-> !st_q[isf_pkg::ST_ERROR_STOP_FLAG])
        else $error("error stop kept after interface flag clear");
    a_dbuf_rd_clr: assert property (acc_rd && avs_address == isf_pkg::OFS_DATA
        ##0 s_quiet |=> !xf_q[isf_pkg::XF_RBF] && !st_q[isf_pkg::ST_ADZ] && !st_q[isf_pkg::ST_AAS])
        else $error("buffer read did not clear flags");
    a_stop_normal: assert property (slave && ev_stop && !frame_busy
        |=> st_q[isf_pkg::ST_STOP] && !st_q[isf_pkg::ST_ERROR_STOP_FLAG])
        else $error("normal stop not set");
    a_continuous_transfer_irq_flag_with_interface_irq_flag: assert property ($rose(st_q[isf_pkg::ST_CONTINUOUS_TRANSFER_IRQ_FLAG]) |-> interface_irq_flag_q)
        else $error("continuous flag without interface flag");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:2] !avs_waitrequest)
        else $error("bus request not answered");
endmodule // isf_slave_flags

// ===== verif/isf_bus_master_model.sv
`timescale 1ns/1ps
// Far-side bus master, seen through the serial bit engine as pulses
module isf_bus_master_model (
    input wire logic core_clk, // System clock
    output logic ev_start, // Start condition pulse
    output logic ev_stop, // Stop condition pulse
    output logic ev_addr, // First frame done pulse
    output logic ev_tx_end, // Transmit frame end pulse
    output logic ev_rx_end, // Receive frame end pulse
    output logic ev_arb_lost, // Arbitration lost pulse
    output logic match_first, // First address hit
    output logic match_second, // Second address hit
    output logic match_gcall, // General call hit
    output logic rw_bit, // Read/write bit
    output logic frame_busy, // Frame in transfer
    output logic ack_in, // Ack bit at transmit end
    output logic [7:0] rx_data // Received byte
);
    // Qualifiers start as junk; they only mean something with their pulse
    initial
    begin
        {ev_start, ev_stop, ev_addr, ev_tx_end, ev_rx_end, ev_arb_lost} = 6'h00;
        {match_first, match_second, match_gcall, rw_bit, frame_busy, ack_in} = 6'h2A;
        rx_data = 8'h00;
    end

    // One-cycle pulse; qualifiers inverted after so stale levels never help
    task automatic pulse(input logic [5:0] ev, input logic [5:0] q);
    begin
        @(posedge core_clk);
        {ev_start, ev_stop, ev_addr, ev_tx_end, ev_rx_end, ev_arb_lost} <= ev;
        {match_first, match_second, match_gcall, rw_bit, frame_busy, ack_in} <= q;
        @(posedge core_clk);
        {ev_start, ev_stop, ev_addr, ev_tx_end, ev_rx_end, ev_arb_lost} <= 6'h00;
        {match_first, match_second, match_gcall, rw_bit, frame_busy, ack_in} <= ~q;
    end
    endtask

    // Bus conditions and frame ends as the master produces them
    task automatic start_cond();
        pulse(6'h20, 6'h00);
    endtask
    task automatic addr(input logic f, input logic s, input logic rw);
        pulse(6'h08, {f, s, 1'b0, rw, 2'b00});
    endtask
    task automatic tx_end(input logic ack);
        pulse(6'h04, {5'h00, ack});
    endtask
    task automatic rx_end(input logic [7:0] d);
        rx_data <= d;
        pulse(6'h02, 6'h00);
    endtask
    task automatic stop_cond(input logic busy);
        pulse(6'h10, {4'h0, busy, 1'b0});
    endtask
    task automatic arb();
        pulse(6'h01, 6'h00);
    endtask
endmodule // isf_bus_master_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic core_clk, srst, avs_read, avs_write, avs_waitrequest, tx_load;
    logic transmit_select, bus_busy_flag, irq, load_seen;
    logic ev_start, ev_stop, ev_addr, ev_tx_end, ev_rx_end, ev_arb_lost;
    logic match_first, match_second, match_gcall, rw_bit, frame_busy, ack_in;
    logic [4:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [7:0] rx_data, tx_data;
    int error_cnt, n_tests;

    isf_slave_flags dut (.core_clk, .srst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ev_start,
        .ev_stop, .ev_addr, .match_first, .match_second, .match_gcall, .rw_bit,
        .ev_tx_end, .ev_rx_end, .frame_busy, .ack_in, .ev_arb_lost, .rx_data,
        .tx_data, .tx_load, .transmit_select, .bus_busy_flag, .irq);
    isf_bus_master_model mdl (.core_clk, .ev_start, .ev_stop, .ev_addr, .ev_tx_end,
        .ev_rx_end, .ev_arb_lost, .match_first, .match_second, .match_gcall, .rw_bit,
        .frame_busy, .ack_in, .rx_data);

    // Free-running 125 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Load pulse lasts one cycle, so latch it for later judging
    always @(posedge core_clk)
        if (tx_load === 1'b1)
            load_seen <= 1'b1;

    task automatic tally_and_finish();
    begin
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    begin
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask

    // One Avalon access; request held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
        input logic [3:0] be);
        int i;
    begin
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        for (i = 0; i < 40; i++)
        begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 40)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        acc(1'b1, a, d, 4'h1);
    endtask

    task automatic rdc(input string what, input logic [4:0] a, input logic [31:0] exp);
    begin
        acc(1'b0, a, 8'h00, 4'hF);
        chk(what, rd, exp);
    end
    endtask

    // Reset values, including an unmapped read
    task automatic s_reset();
    begin
        rdc("status", isf_pkg::OFS_STATUS, 32'h00);
        rdc("xfer", isf_pkg::OFS_XFER, 32'h00);
        rdc("ctrl", isf_pkg::OFS_CTRL, 32'h00);
        rdc("unmapped", 5'h18, 32'h00);
    end
    endtask

    // First address, receive, buffer reads, normal stop
    task automatic s_first_rx();
    begin
        mdl.start_cond();
        rdc("xfer start", isf_pkg::OFS_XFER, 32'h05);
        mdl.addr(1'b1, 1'b0, 1'b0);
        rdc("status first", isf_pkg::OFS_STATUS, 32'h04);
        rdc("xfer first", isf_pkg::OFS_XFER, 32'h07);
        acc(1'b0, isf_pkg::OFS_DATA, 8'h00, 4'hF);
        rdc("status rd", isf_pkg::OFS_STATUS, 32'h00);
        rdc("xfer rd", isf_pkg::OFS_XFER, 32'h05);
        mdl.rx_end(8'h3C);
        rdc("xfer rx", isf_pkg::OFS_XFER, 32'h07);
        rdc("status rx", isf_pkg::OFS_STATUS, 32'h00);
        rdc("data", isf_pkg::OFS_DATA, 32'h3C);
        rdc("xfer rd2", isf_pkg::OFS_XFER, 32'h05);
        mdl.stop_cond(1'b0);
        rdc("status stop", isf_pkg::OFS_STATUS, 32'h40);
        rdc("xfer stop", isf_pkg::OFS_XFER, 32'h00);
        wr(isf_pkg::OFS_STATUS, 8'h00);
        rdc("ctrl", isf_pkg::OFS_CTRL, 32'h01);
        wr(isf_pkg::OFS_CTRL, 8'h00);
    end
    endtask

    // Second address, transmit, arbitration loss, error stop and its clear
    task automatic s_second_tx();
    begin
        mdl.start_cond();
        acc(1'b0, isf_pkg::OFS_CTRL, 8'h00, 4'hF);
        wr(isf_pkg::OFS_CTRL, 8'h00);
        mdl.addr(1'b0, 1'b1, 1'b1);
        rdc("status second", isf_pkg::OFS_STATUS, 32'h30);
        rdc("xfer second", isf_pkg::OFS_XFER, 32'h0F);
        chk("trs pin", {31'h0, transmit_select}, 32'h1);
        chk("busy pin", {31'h0, bus_busy_flag}, 32'h1);
        rdc("ctrl second", isf_pkg::OFS_CTRL, 32'h01);
        mdl.arb();
        rdc("status lost", isf_pkg::OFS_STATUS, 32'h38);
        load_seen = 1'b0;
        wr(isf_pkg::OFS_DATA, 8'h96);
        rdc("status wr", isf_pkg::OFS_STATUS, 32'h30);
        chk("tx_data", {24'h0, tx_data}, 32'h96);
        chk("tx_load", {31'h0, load_seen}, 32'h1);
        rdc("xfer wr", isf_pkg::OFS_XFER, 32'h0E);
        wr(isf_pkg::OFS_STATUS, 8'hDF);
        rdc("status clr", isf_pkg::OFS_STATUS, 32'h10);
        mdl.tx_end(1'b0);
        rdc("xfer tx", isf_pkg::OFS_XFER, 32'h0F);
        rdc("status tx", isf_pkg::OFS_STATUS, 32'h30);
        mdl.stop_cond(1'b1);
        rdc("status estop", isf_pkg::OFS_STATUS, 32'hB0);
        rdc("xfer estop", isf_pkg::OFS_XFER, 32'h0A);
        chk("busy pin stop", {31'h0, bus_busy_flag}, 32'h0);
        chk("trs pin stop", {31'h0, transmit_select}, 32'h1);
        wr(isf_pkg::OFS_STATUS, 8'hFF);
        rdc("status w1", isf_pkg::OFS_STATUS, 32'hB0);
        wr(isf_pkg::OFS_STATUS, 8'h7F);
        rdc("status w0", isf_pkg::OFS_STATUS, 32'h30);
    end
    endtask

    // Error stop dropped by clearing the interface flag
    task automatic s_interface_irq_flag_clear();
    begin
        mdl.start_cond();
        rdc("status restart", isf_pkg::OFS_STATUS, 32'h20);
        mdl.stop_cond(1'b1);
        rdc("status estop2", isf_pkg::OFS_STATUS, 32'hA0);
        rdc("ctrl", isf_pkg::OFS_CTRL, 32'h01);
        wr(isf_pkg::OFS_CTRL, 8'h00);
        rdc("status interface_irq_flag", isf_pkg::OFS_STATUS, 32'h00);
    end
    endtask

    // Master mode freezes slave flags; a stop there is no error stop
    task automatic s_master();
    begin
        wr(isf_pkg::OFS_CTRL, 8'h02);
        rdc("ctrl ms", isf_pkg::OFS_CTRL, 32'h02);
        mdl.start_cond();
        mdl.stop_cond(1'b1);
        rdc("status ms", isf_pkg::OFS_STATUS, 32'h00);
        rdc("xfer ms", isf_pkg::OFS_XFER, 32'h0A);
        wr(isf_pkg::OFS_CTRL, 8'h00);
        rdc("ctrl slave", isf_pkg::OFS_CTRL, 32'h00);
    end
    endtask

    // Interrupt: raise while masked, unmask, clear; lane-less write ignored
    task automatic s_irq();
    begin
        wr(isf_pkg::OFS_IRQ_ST, 8'h1F);
        rdc("irq st", isf_pkg::OFS_IRQ_ST, 32'h00);
        acc(1'b1, isf_pkg::OFS_IRQ_MASK, 8'h01, 4'hE);
        rdc("mask be", isf_pkg::OFS_IRQ_MASK, 32'h00);
        mdl.start_cond();
        rdc("irq st start", isf_pkg::OFS_IRQ_ST, 32'h01);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(isf_pkg::OFS_IRQ_MASK, 8'h01);
        rdc("mask", isf_pkg::OFS_IRQ_MASK, 32'h01);
        chk("irq on", {31'h0, irq}, 32'h1);
        wr(isf_pkg::OFS_IRQ_ST, 8'h01);
        rdc("irq st clr", isf_pkg::OFS_IRQ_ST, 32'h00);
        chk("irq off", {31'h0, irq}, 32'h0);
    end
    endtask

    // Reset for three cycles, then the scenarios in order
    initial
    begin
        error_cnt = 0;
        n_tests = 0;
        load_seen = 1'b0;
        srst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        s_reset();
        s_first_rx();
        s_second_tx();
        s_interface_irq_flag_clear();
        s_master();
        s_irq();
        tally_and_finish();
    end
endmodule // tb_top
